//--- logic/gpcfg_access.sv
// gpcfg_access: indirect per-pin configuration access with event detection
// assumes host strobes are one-cycle pulses on clk_sys; pins are asynchronous
//
// Overview of operation
// - select codes 110000..111111 pick pins 48..63 ascending
// - access register reads and writes touch only the selected pin
// - bank 1 indices 00000..01111 pick pins 32..47, events active there
// - event bits read zero and do nothing on non-event pins
// - bit 6 enables 16 ms debounce, reset value 1
// - bit 5 polarity: 0 falling/low, 1 rising/high
// - pin 63 may drive the internal power-button input
// - bit 4 selects edge (0) or level (1) detection
// - bit 0 enables the pin driver, else input only
module gpcfg_access
   import gpcfg_pkg::*;
#(
   parameter int DEB_CYC = DEBOUNCE_CYC
)
(
   input wire logic clk_sys, // system clock
   input wire logic rst_n, // async reset, active low
   input wire gpcfg_req_t req, // host access strobes and data
   input wire logic [NUM_PINS-1:0] pinIn, // pad inputs
   output logic [31:0] rdata_r, // read data
   output logic [NUM_PINS-1:0] pinOut_r, // pad output values
   output logic [NUM_PINS-1:0] pinOe_r, // pad output enables
   output logic [NUM_PINS-1:0] pinPullup_r, // pad pull-up enables
   output logic [NUM_PINS-1:0] powerMgmtEvent_r, // event pulses in edge mode, levels in level mode
   output logic powerButtonInput_r // power-button level from pin 63
);
   // ==========================================================
   // selection
   logic [SEL_W-1:0] sel_r;
   logic [CFG_W-1:0] cfg_r [NUM_PINS];
   // output values live outside this block; held low so enabled open-drain pins pull low
   logic [NUM_PINS-1:0] outVal_r;
   wire logic [5:0] pinIdx = sel_r;
   wire logic selEvtPin = ~pinIdx[4];
   wire logic [CFG_W-1:0] selCfg = cfg_r[pinIdx];
   wire logic [CFG_W-1:0] wrMask = selEvtPin ? 7'h7f : ~CFG_EVT_MASK;
   wire logic [CFG_W-1:0] wrVal = req.wdata[CFG_W-1:0] & wrMask;
   wire logic [CFG_W-1:0] lockMask = 7'h17;
   // lock freezes direction, type, pull-up and edge/level; keeps polarity and debounce bits writable
   wire logic [CFG_W-1:0] wrNxt = selCfg[BIT_LOCK] ?
      ((selCfg & lockMask) | (wrVal & ~lockMask) | 7'h08) : wrVal;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         sel_r <= SEL_RESET;
      else if (req.selWr)
         sel_r <= req.wdata[SEL_W-1:0];
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++)
      begin : g_pin
         localparam bit EVT = (gi < 16) || (gi >= 32 && gi < 48);
         localparam logic [6:0] RST = EVT ? CFG_RESET : (CFG_RESET & ~CFG_EVT_MASK);
         logic [2:0] sync_r;
         logic stable_r;
         logic stablePrev_r;
         logic [$clog2(DEB_CYC+1)-1:0] cnt_r;
         wire logic wrHere = req.wr && (pinIdx == 6'(gi));
         wire logic agree = (sync_r[1] == sync_r[2]);
         wire logic [6:0] c = cfg_r[gi];
         wire logic deb = c[BIT_DEBEN];
         wire logic active = (stable_r == c[BIT_POL]);
         wire logic edgeHit = (stable_r != stablePrev_r) && active;
         wire logic trig = c[BIT_LEVEL] ? active : edgeHit;

         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
               cfg_r[gi] <= RST;
            else if (wrHere)
               cfg_r[gi] <= wrNxt;
         end

         // third stage compared with second so a change counts once both agree
         // any disagreement restarts the count, so a glitch never shortens the filter
         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
            begin
               sync_r <= 3'h7;
               stable_r <= 1'b1;
               stablePrev_r <= 1'b1;
               cnt_r <= '0;
            end
            else
            begin
               sync_r <= {sync_r[1:0], pinIn[gi]};
               stablePrev_r <= stable_r;
               if (!agree || sync_r[2] == stable_r)
                  cnt_r <= '0;
               else if (!deb || cnt_r == ($bits(cnt_r))'(DEB_CYC - 1))
               begin
                  stable_r <= sync_r[2];
                  cnt_r <= '0;
               end
               else
                  cnt_r <= cnt_r + 1'b1;
            end
         end

         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
               powerMgmtEvent_r[gi] <= 1'b0;
            else
               powerMgmtEvent_r[gi] <= EVT && trig;
         end
      end
   endgenerate

   // ==========================================================
   // pad drive and read-back
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         outVal_r <= '0;
         pinOut_r <= '0;
         pinOe_r <= '0;
         pinPullup_r <= '0;
         rdata_r <= '0;
         powerButtonInput_r <= 1'b1;
      end
      else
      begin
         for (int i = 0; i < NUM_PINS; i++)
         begin
            // open-drain drives only a low
            pinOe_r[i] <= cfg_r[i][BIT_OUTEN] &&
               (cfg_r[i][BIT_OTYPE] || !outVal_r[i]);
            pinOut_r[i] <= outVal_r[i];
            pinPullup_r[i] <= cfg_r[i][BIT_PULLUP] && cfg_r[i][1:0] == 2'b01;
         end
         powerButtonInput_r <= g_pin[NUM_PINS-1].stable_r;
         if (req.rd)
            rdata_r <= {25'h0, selCfg};
         else if (req.selRd)
            rdata_r <= {26'h0, sel_r};
      end
   end

   // ==========================================================
   // checks
   property p_sel_track;
      @(posedge clk_sys) disable iff (!rst_n)
      req.selWr |=> sel_r == $past(req.wdata[5:0]);
   endproperty
   a_sel_track: assert property (p_sel_track) else $error("select not captured");
   property p_selrd;
      @(posedge clk_sys) disable iff (!rst_n)
      req.selRd && !req.rd |=> rdata_r == {26'h0, $past(sel_r)};
   endproperty
   a_selrd: assert property (p_selrd) else $error("select read back wrong");
   property p_wr_only_sel;
      @(posedge clk_sys) disable iff (!rst_n)
      req.wr && sel_r != 6'h28 |=> $stable(cfg_r[40]);
   endproperty
   a_wr_only_sel: assert property (p_wr_only_sel) else $error("write hit unselected pin");
   property p_rd_sel;
      @(posedge clk_sys) disable iff (!rst_n)
      req.rd |=> rdata_r[6:0] == $past(selCfg) && rdata_r[31:7] == 25'h0;
   endproperty
   a_rd_sel: assert property (p_rd_sel) else $error("read not from selected pin");
   property p_noevt_zero;
      @(posedge clk_sys) disable iff (!rst_n)
      req.rd && !selEvtPin |=> rdata_r[6:4] == 3'h0;
   endproperty
   a_noevt_zero: assert property (p_noevt_zero) else $error("event bits nonzero");
   property p_bank1;
      @(posedge clk_sys) disable iff (!rst_n)
      req.wr && sel_r[5:4] == 2'b10 |=> cfg_r[$past(sel_r)][6:4] == $past(req.wdata[6:4]);
   endproperty
   a_bank1: assert property (p_bank1) else $error("bank 1 event bits lost");
   property p_power_button_input;
      @(posedge clk_sys) disable iff (!rst_n)
      ##1 powerButtonInput_r == $past(g_pin[63].stable_r);
   endproperty
   a_power_button_input: assert property (p_power_button_input) else $error("power button not from pin 63");
   property p_oe;
      @(posedge clk_sys) disable iff (!rst_n)
      !cfg_r[5][BIT_OUTEN] |=> !pinOe_r[5];
   endproperty
   a_oe: assert property (p_oe) else $error("driver on while disabled");
   property p_oe_on;
      @(posedge clk_sys) disable iff (!rst_n)
      cfg_r[32][BIT_OUTEN] |=> pinOe_r[32];
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("driver off while enabled");
   property p_noevt_pin;
      @(posedge clk_sys) disable iff (!rst_n)
      !powerMgmtEvent_r[20] && !powerMgmtEvent_r[63];
   endproperty
   a_noevt_pin: assert property (p_noevt_pin) else $error("event on non-event pin");
   property p_deb;
      @(posedge clk_sys) disable iff (!rst_n)
      $past(cfg_r[32][BIT_DEBEN]) && $changed(g_pin[32].stable_r) |->
         $past(g_pin[32].cnt_r) == ($bits(g_pin[32].cnt_r))'(DEB_CYC - 1);
   endproperty
   a_deb: assert property (p_deb) else $error("debounce ended early");
   property p_pol;
      @(posedge clk_sys) disable iff (!rst_n)
      powerMgmtEvent_r[32] |-> $past(g_pin[32].stable_r) == $past(cfg_r[32][BIT_POL]);
   endproperty
   a_pol: assert property (p_pol) else $error("event against polarity");
   property p_evt_pulse;
      @(posedge clk_sys) disable iff (!rst_n)
      powerMgmtEvent_r[32] && !cfg_r[32][BIT_LEVEL] |=> !powerMgmtEvent_r[32];
   endproperty
   a_evt_pulse: assert property (p_evt_pulse) else $error("edge event too long");
   // ==========================================================
   // main scenarios
   c_evt: cover property (@(posedge clk_sys) powerMgmtEvent_r[0]);
   c_evt32: cover property (@(posedge clk_sys) powerMgmtEvent_r[32]);
   c_wr63: cover property (@(posedge clk_sys) req.wr && sel_r == SEL_POWER_BUTTON_INPUT);
   c_power_button_input: cover property (@(posedge clk_sys) $fell(powerButtonInput_r));
   c_selrd: cover property (@(posedge clk_sys) req.selRd);
endmodule // gpcfg_access

//--- logic/gpcfg_pkg.sv
// gpcfg_pkg: constants and types for the per-pin configuration access block
// assumes a 200 MHz system clock and a 64-pin general-purpose port
package gpcfg_pkg;
   // ==========================================================
   // select register layout
   localparam int SEL_W = 6;
   localparam int SEL_BANK_BIT = 5;
   localparam logic [5:0] SEL_RESET = 6'h00;
   localparam logic [5:0] SEL_POWER_BUTTON_INPUT = 6'h3f;
   // ==========================================================
   // access register layout
   localparam int BIT_OUTEN = 0;
   localparam int BIT_OTYPE = 1;
   localparam int BIT_PULLUP = 2;
   localparam int BIT_LOCK = 3;
   localparam int BIT_LEVEL = 4;
   localparam int BIT_POL = 5;
   localparam int BIT_DEBEN = 6;
   localparam int CFG_W = 7;
   localparam logic [6:0] CFG_RESET = 7'h44;
   localparam logic [6:0] CFG_EVT_MASK = 7'h70;
   // ==========================================================
   // timing
   localparam int CLK_MHZ = 200;
   localparam int DEBOUNCE_MS = 16;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ;
   localparam int NUM_PINS = 64;

   typedef struct packed {
      logic wr;
      logic rd;
      logic selWr;
      logic selRd;
      logic [31:0] wdata;
   } gpcfg_req_t;
endpackage

//--- tb/gpcfg_access_bench.sv
// gpcfg_access_bench: random and corner tests of per-pin config access
// assumes a short debounce count so event timing fits the run
module gpcfg_access_bench;
   import gpcfg_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   gpcfg_req_t req;
   logic [63:0] pinIn = '1;
   logic [31:0] rdata;
   logic [63:0] oe, ev, oeExp;
   logic [63:0] pull, pullExp, pout;
   logic power_button_input;
   int errors = 0, n_tests = 0, cycles = 0, ev32 = 0, ev16 = 0;
   logic [6:0] cfgExp [64];
   always #2.5 clk_sys = ~clk_sys;
   gpcfg_host host (.clk_sys(clk_sys), .req(req));
   gpcfg_access #(.DEB_CYC(8)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
      .pinIn(pinIn), .rdata_r(rdata), .pinOut_r(pout), .pinOe_r(oe), .pinPullup_r(pull),
      .powerMgmtEvent_r(ev), .powerButtonInput_r(power_button_input));
   // ==========
   task automatic end_sim();
      $display("errors %0d, comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // event bits vanish on non-event pins
   function automatic logic [6:0] expv(int p, logic [6:0] v);
      return p[4] ? (v & ~CFG_EVT_MASK) : v;
   endfunction
   task automatic rdPin(input int p);
      host.access(0, p);
      host.access(3, 0);
      check(rdata, p);
      host.access(2, 0);
      check(rdata, {25'h0, cfgExp[p]});
   endtask
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (ev[32] === 1'b1) ev32 <= ev32 + 1;
      if (ev[16] === 1'b1) ev16 <= ev16 + 1;
      if (cycles == 5000)
      begin
         errors++;
         end_sim();
      end
   end
   // ==========
   initial
   begin
      int p;
      logic [6:0] v;
      void'($urandom(32'h8c16));
      foreach (cfgExp[i]) cfgExp[i] = expv(i, CFG_RESET);
      repeat (4) @(negedge clk_sys);
      rst_n = 1'b1;
      rdPin(0);
      rdPin(16);
      rdPin(63);
      // rising polarity on an event pin and a non-event pin
      host.access(0, 32);
      host.access(1, 32'h60);
      host.access(0, 16);
      host.access(1, 32'h60);
      cfgExp[32] = expv(32, 7'h60);
      cfgExp[16] = expv(16, 7'h60);
      pinIn[32] = 1'b0;
      pinIn[16] = 1'b0;
      repeat (30) @(negedge clk_sys);
      pinIn[32] = 1'b1;
      pinIn[16] = 1'b1;
      repeat (10) @(negedge clk_sys);
      check(ev32, 0);
      repeat (25) @(negedge clk_sys);
      check(ev32, 1);
      check(ev16, 0);
      rdPin(32);
      pinIn[63] = 1'b0;
      repeat (40) @(negedge clk_sys);
      check(power_button_input, 0);
      repeat (40)
      begin
         p = $urandom_range(63);
         v = 7'($urandom) & 7'h67;
         host.access(0, p);
         host.access(1, v);
         cfgExp[p] = expv(p, v);
         rdPin($urandom_range(63));
         rdPin(p);
         foreach (oeExp[i])
         begin
            oeExp[i] = cfgExp[i][0];
            pullExp[i] = cfgExp[i][2] && cfgExp[i][1:0] == 2'b01;
         end
         check(oe, oeExp);
         check(pull, pullExp);
         check(pout, 64'h0);
      end
      end_sim();
   end
endmodule // gpcfg_access_bench

//--- tb/gpcfg_host.sv
// gpcfg_host: host software model issuing strobed register accesses
// assumes strobes are sampled on the rising edge of clk_sys
module gpcfg_host
   import gpcfg_pkg::*;
(
   output gpcfg_req_t req // access strobes and data
   , input wire logic clk_sys // system clock
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   // ==========
   // kind 0 select write, 1 config write, 2 config read, 3 select read
   // edge/level is kept at edge on config writes; select codes pass whole
   task automatic access(input int kind, input logic [31:0] d);
      @(negedge clk_sys);
      req.wdata = (kind == 1) ? {25'h0, d[6:0] & 7'h6f} : {26'h0, d[5:0]};
      req.selWr = (kind == 0);
      req.wr = (kind == 1);
      req.rd = (kind == 2);
      req.selRd = (kind == 3);
      @(negedge clk_sys);
      req = '0;
   endtask
endmodule // gpcfg_host
